//--- logic/lsp_map.svh
`ifndef LSP_MAP_SVH
`define LSP_MAP_SVH

`define LSP_ADDR_W 8
`define LSP_OFF_CRC_LOW 8'h0A
`define LSP_OFF_CRC_HIGH 8'h0B
`define LSP_OFF_STATUS 8'h0C
`define LSP_OFF_PIN0_CFG 8'h0D

`define LSP_ST_LINK_LOST 4
`define LSP_ST_BIST_ERR 3
`define LSP_ST_TMDS_CLK 2
`define LSP_ST_DES_ERR 1
`define LSP_ST_LINK_DET 0

`define LSP_CFG_REV_MSB 7
`define LSP_CFG_REV_LSB 4
`define LSP_CFG_VALUE 3
`define LSP_CFG_MODE_MSB 2
`define LSP_CFG_MODE_LSB 0

`define LSP_RST_COUNT 16'h0000
`define LSP_RST_BYTE 8'h00
`define LSP_RST_VALUE 1'h0
`define LSP_RST_MODE 3'h0
`define LSP_COUNT_MAX 16'hFFFF
`define LSP_COUNT_ONE 16'h0001

`endif

//--- logic/lsp_pkg.sv
`default_nettype none
package lsp_pkg;

  typedef logic [2:0] lsp_mode_t;

  typedef enum logic [2:0] {
    LSP_FN_INPUT,
    LSP_FN_TRISTATE,
    LSP_FN_GP_OUT,
    LSP_FN_GP_IN,
    LSP_FN_REMOTE_HOLD,
    LSP_FN_REMOTE_DEFAULT
  } lsp_pin_fn_t;

  // Pattern x00 and x10 ignore the top bit
  function automatic lsp_pin_fn_t lsp_decode_mode(input lsp_mode_t mode);
    lsp_pin_fn_t fn;
    fn = LSP_FN_INPUT;
    case (mode)
      3'h0, 3'h4: fn = LSP_FN_INPUT;
      3'h2, 3'h6: fn = LSP_FN_TRISTATE;
      3'h1: fn = LSP_FN_GP_OUT;
      3'h3: fn = LSP_FN_GP_IN;
      3'h5: fn = LSP_FN_REMOTE_HOLD;
      3'h7: fn = LSP_FN_REMOTE_DEFAULT;
      default: fn = LSP_FN_INPUT;
    endcase
    return fn;
  endfunction

endpackage
`default_nettype wire

//--- logic/lsp_port_status.sv
`timescale 1ns/100ps
`default_nettype none
`include "lsp_map.svh"

module lsp_port_status (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Synchronised reset, active low
  input wire logic i_crc_err, // Back-channel CRC error, one-cycle pulse
  input wire logic i_bist_active, // Self-test running on this port
  input wire logic i_bist_start, // Self-test restart pulse
  input wire logic i_link_detect, // Live cable link detect
  input wire logic i_err_reset, // Error-reset control level
  output logic [15:0] o_crc_count, // Back-channel CRC error count
  output logic o_link_lost, // Sticky link lost flag
  output logic o_bist_err, // Sticky self-test CRC error flag
  output logic o_des_err // Sticky normal-mode CRC error flag
);
  logic [15:0] count;
  logic link_lost;
  logic bist_err;
  logic des_err;
  logic link_prev;
  logic [15:0] next_count;
  logic next_link_lost;
  logic next_bist_err;
  logic next_des_err;
  logic loss_evt;

  // Loss of link is the falling edge of link detect
  assign loss_evt = link_prev & ~i_link_detect;

  always_comb begin
    next_count = count;
    if (i_err_reset) begin
      next_count = `LSP_RST_COUNT;
    end
    if (i_crc_err) begin
      if (i_err_reset) begin
        next_count = `LSP_COUNT_ONE;
      end else if (count != `LSP_COUNT_MAX) begin
        next_count = count + `LSP_COUNT_ONE;
      end
    end
    next_link_lost = link_lost;
    if (i_err_reset) begin
      next_link_lost = 1'b0;
    end
    if (loss_evt) begin
      next_link_lost = 1'b1;
    end
    next_bist_err = bist_err;
    if (i_err_reset || loss_evt || i_bist_start) begin
      next_bist_err = 1'b0;
    end
    if (i_crc_err && i_bist_active) begin
      next_bist_err = 1'b1;
    end
    next_des_err = des_err;
    if (i_err_reset || loss_evt) begin
      next_des_err = 1'b0;
    end
    if (i_crc_err && !i_bist_active) begin
      next_des_err = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count <= `LSP_RST_COUNT;
      link_lost <= 1'b0;
      bist_err <= 1'b0;
      des_err <= 1'b0;
      link_prev <= 1'b0;
    end else begin
      count <= next_count;
      link_lost <= next_link_lost;
      bist_err <= next_bist_err;
      des_err <= next_des_err;
      link_prev <= i_link_detect;
    end
  end

  assign o_crc_count = count;
  assign o_link_lost = link_lost;
  assign o_bist_err = bist_err;
  assign o_des_err = des_err;

endmodule
`default_nettype wire

//--- logic/lsp_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "lsp_map.svh"

module lsp_regs #(
  parameter logic [3:0] REVISION = 4'h1 // Arbitrary revision value
) (
  input wire logic i_sys_clk, // 40 MHz system clock
  input wire logic i_resetn, // Async reset, active low
  input wire logic [7:0] i_reg_addr, // Register address
  input wire logic i_reg_wr, // Register write strobe
  input wire logic [7:0] i_reg_wdata, // Register write data
  output logic [7:0] o_reg_rdata, // Registered read data
  input wire logic i_second_port_select, // Port 1 select level
  input wire logic i_err_reset, // Error-reset control level
  input wire logic [1:0] i_crc_err, // CRC error pulse per port
  input wire logic [1:0] i_bist_active, // Self-test running per port
  input wire logic [1:0] i_bist_start, // Self-test restart per port
  input wire logic [1:0] i_link_detect, // Link detect per port
  input wire logic i_tmds_clk_valid, // Valid video clock present
  input wire logic i_remote_pin_value, // Pin value from remote side
  input wire logic i_general_pin_zero_in, // Pin level in
  output logic o_general_pin_zero_out, // Pin level out
  output logic o_general_pin_zero_oe_n, // Pin enable, low drives
  output logic o_pin_to_remote, // Sampled pin level for link
  output lsp_pkg::lsp_mode_t o_remote_side_pin_zero_mode, // Port 1 mode
  output logic o_remote_side_pin_zero_value // Port 1 output value
);
  import lsp_pkg::*;

  logic rst_sync1;
  logic rst_n;
  logic [15:0] count [2];
  logic [1:0] link_lost;
  logic [1:0] bist_err;
  logic [1:0] des_err;
  logic sel;

  lsp_mode_t mode_local;
  logic value_local;
  lsp_mode_t mode_remote;
  logic value_remote;
  logic held;
  logic pin_out;
  logic pin_oe_n;
  logic pin_to_remote;
  logic [7:0] rdata;
  lsp_mode_t next_mode_local;
  logic next_value_local;
  lsp_mode_t next_mode_remote;
  logic next_value_remote;
  logic next_held;
  logic next_pin_out;
  logic next_pin_oe_n;
  logic next_pin_to_remote;
  logic [7:0] next_rdata;
  lsp_pin_fn_t fn;
  logic wr_cfg;

  // Config readback: revision nibble over value bit and mode
  function automatic logic [7:0] cfg_byte(input logic value,
                                          input lsp_mode_t mode);
    logic [7:0] b;
    b = `LSP_RST_BYTE;
    b[`LSP_CFG_REV_MSB:`LSP_CFG_REV_LSB] = REVISION;
    b[`LSP_CFG_VALUE] = value;
    b[`LSP_CFG_MODE_MSB:`LSP_CFG_MODE_LSB] = mode;
    return b;
  endfunction

  // One port's status byte; reserved top bits read zero
  function automatic logic [7:0] status_byte(input logic lost,
                                             input logic bist,
                                             input logic tmds,
                                             input logic des,
                                             input logic det);
    logic [7:0] b;
    b = `LSP_RST_BYTE;
    b[`LSP_ST_LINK_LOST] = lost;
    b[`LSP_ST_BIST_ERR] = bist;
    b[`LSP_ST_TMDS_CLK] = tmds;
    b[`LSP_ST_DES_ERR] = des;
    b[`LSP_ST_LINK_DET] = det;
    return b;
  endfunction

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_sync1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1 <= 1'b1;
      rst_n <= rst_sync1;
    end
  end

  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      lsp_port_status u_status (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n),
        .i_crc_err(i_crc_err[p]),
        .i_bist_active(i_bist_active[p]),
        .i_bist_start(i_bist_start[p]),
        .i_link_detect(i_link_detect[p]),
        .i_err_reset(i_err_reset),
        .o_crc_count(count[p]),
        .o_link_lost(link_lost[p]),
        .o_bist_err(bist_err[p]),
        .o_des_err(des_err[p])
      );
    end
  endgenerate

  assign sel = i_second_port_select;
  assign fn = lsp_decode_mode(mode_local);
  // Only the config offset takes writes
  assign wr_cfg = i_reg_wr && (i_reg_addr == `LSP_OFF_PIN0_CFG);

  // Configuration registers, local pin and port 1 remote pin
  always_comb begin
    next_mode_local = mode_local;
    next_value_local = value_local;
    next_mode_remote = mode_remote;
    next_value_remote = value_remote;
    if (wr_cfg) begin
      if (sel) begin
        next_mode_remote = i_reg_wdata[`LSP_CFG_MODE_MSB:`LSP_CFG_MODE_LSB];
        next_value_remote = i_reg_wdata[`LSP_CFG_VALUE];
      end else begin
        next_mode_local = i_reg_wdata[`LSP_CFG_MODE_MSB:`LSP_CFG_MODE_LSB];
        next_value_local = i_reg_wdata[`LSP_CFG_VALUE];
      end
    end
  end

  // Local pin drive; remote value tracks only while port 0 link is up
  always_comb begin
    next_held = held;
    if (i_link_detect[0]) begin
      next_held = i_remote_pin_value;
    end
    next_pin_out = 1'b0;
    next_pin_oe_n = 1'b1;
    next_pin_to_remote = pin_to_remote;
    case (fn)
      LSP_FN_INPUT: begin
        next_pin_oe_n = 1'b1;
      end
      LSP_FN_TRISTATE: begin
        next_pin_oe_n = 1'b1;
      end
      LSP_FN_GP_OUT: begin
        next_pin_oe_n = 1'b0;
        next_pin_out = value_local;
      end
      LSP_FN_GP_IN: begin
        next_pin_oe_n = 1'b1;
        next_pin_to_remote = i_general_pin_zero_in;
      end
      LSP_FN_REMOTE_HOLD: begin
        next_pin_oe_n = 1'b0;
        next_pin_out = next_held;
      end
      LSP_FN_REMOTE_DEFAULT: begin
        next_pin_oe_n = 1'b0;
        next_pin_out = i_link_detect[0] ? i_remote_pin_value
                                        : value_local;
      end
      default: begin
        next_pin_oe_n = 1'b1;
      end
    endcase
  end

  // Read path; writes to read-only offsets touch nothing
  always_comb begin
    next_rdata = `LSP_RST_BYTE;
    case (i_reg_addr)
      `LSP_OFF_CRC_LOW: begin
        next_rdata = count[sel][7:0];
      end
      `LSP_OFF_CRC_HIGH: begin
        next_rdata = count[sel][15:8];
      end
      `LSP_OFF_STATUS: begin
        next_rdata = status_byte(link_lost[sel], bist_err[sel],
                                 i_tmds_clk_valid, des_err[sel],
                                 i_link_detect[sel]);
      end
      `LSP_OFF_PIN0_CFG: begin
        next_rdata = sel ? cfg_byte(value_remote, mode_remote)
                         : cfg_byte(value_local, mode_local);
      end
      default: begin
        next_rdata = `LSP_RST_BYTE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_local <= `LSP_RST_MODE;
      value_local <= `LSP_RST_VALUE;
      mode_remote <= `LSP_RST_MODE;
      value_remote <= `LSP_RST_VALUE;
    end else begin
      mode_local <= next_mode_local;
      value_local <= next_value_local;
      mode_remote <= next_mode_remote;
      value_remote <= next_value_remote;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      held <= 1'b0;
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pin_to_remote <= 1'b0;
    end else begin
      held <= next_held;
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
      pin_to_remote <= next_pin_to_remote;
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= `LSP_RST_BYTE;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_reg_rdata = rdata;
  assign o_general_pin_zero_out = pin_out;
  assign o_general_pin_zero_oe_n = pin_oe_n;
  assign o_pin_to_remote = pin_to_remote;
  assign o_remote_side_pin_zero_mode = mode_remote;
  assign o_remote_side_pin_zero_value = value_remote;

endmodule
`default_nettype wire

//--- testbench/lsp_regs_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module lsp_regs_assertions #(
  parameter logic [3:0] REVISION = 4'h1 // Revision nibble
) (
  input wire logic i_sys_clk, // Clock
  input wire logic i_resetn, // Reset, active low
  input wire logic [7:0] i_reg_addr, // Address
  input wire logic i_reg_wr, // Write strobe
  input wire logic [7:0] i_reg_wdata, // Write data
  input wire logic [7:0] o_reg_rdata, // Read data
  input wire logic i_second_port_select, // Port select
  input wire logic i_err_reset, // Error reset
  input wire logic [1:0] i_crc_err, // CRC pulses
  input wire logic [1:0] i_link_detect, // Link detect
  input wire logic i_tmds_clk_valid, // Video clock
  input wire logic o_general_pin_zero_out, // Pin level
  input wire logic o_general_pin_zero_oe_n, // Pin enable
  input wire lsp_pkg::lsp_mode_t o_remote_side_pin_zero_mode, // Remote mode
  input wire logic o_remote_side_pin_zero_value // Remote value
);
  import lsp_pkg::*;
  logic [1:0] cnt;
  logic [1:0] next_cnt;
  logic rdy;
  // Skip the synchroniser's release cycles
  always_comb next_cnt = (cnt == 2'h3) ? cnt : cnt + 2'h1;
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) cnt <= 2'h0;
    else cnt <= next_cnt;
  end
  assign rdy = (cnt == 2'h3);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_wr_loc;
    rdy && i_reg_wr && i_reg_addr == 8'h0D && !i_second_port_select;
  endsequence
  property p_unmapped;
    rdy && (i_reg_addr < 8'h0A || i_reg_addr > 8'h0D) |=> o_reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("bad unmapped");
  property p_rsvd;
    rdy && i_reg_addr == 8'h0C |=> o_reg_rdata[7:5] == 3'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("status top bits set");
  property p_status;
    rdy && i_reg_addr == 8'h0C && $stable(i_link_detect) &&
      $stable(i_tmds_clk_valid) && $stable(i_second_port_select) |=>
      {o_reg_rdata[2], o_reg_rdata[0]} ==
      $past({i_tmds_clk_valid, i_link_detect[i_second_port_select]});
  endproperty
  a_status: assert property (p_status) else $error("live bits wrong");
  property p_gp_out;
    s_wr_loc ##0 (i_reg_wdata[2:0] == 3'h1) |-> ##2
      !o_general_pin_zero_oe_n &&
      o_general_pin_zero_out == $past(i_reg_wdata[3], 2);
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("local drive");
  property p_no_drive;
    s_wr_loc ##0 (!i_reg_wdata[0] || i_reg_wdata[2:0] == 3'h3) |-> ##2
      o_general_pin_zero_oe_n;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("pin driven");
  property p_remote;
    rdy && i_reg_wr && i_reg_addr == 8'h0D && i_second_port_select |=>
      {o_remote_side_pin_zero_value, o_remote_side_pin_zero_mode} ==
      $past(i_reg_wdata[3:0]);
  endproperty
  a_remote: assert property (p_remote) else $error("remote cfg");
  property p_rdback;
    s_wr_loc ##1 (i_reg_addr == 8'h0D && !i_reg_wr &&
      !i_second_port_select) |=>
      o_reg_rdata == {REVISION, $past(i_reg_wdata[3:0], 2)};
  endproperty
  a_rdback: assert property (p_rdback) else $error("cfg readback");
  property p_clr;
    rdy && i_err_reset && $past(i_err_reset) &&
      $stable(i_second_port_select) && i_crc_err == 2'h0 &&
      $past(i_crc_err) == 2'h0 &&
      (i_reg_addr == 8'h0A || i_reg_addr == 8'h0B) |=> o_reg_rdata == 8'h00;
  endproperty
  a_clr: assert property (p_clr) else $error("count not cleared");
endmodule
`default_nettype wire

//--- testbench/lsp_remote_model.sv
`timescale 1ns/100ps
`default_nettype none
module lsp_remote_model (
  input wire logic [1:0] i_up, // Link wanted up
  input wire logic [1:0] i_err, // CRC error request
  input wire logic i_val, // Pin value sent
  output logic [1:0] o_link, // Link detect
  output logic [1:0] o_crc, // CRC error pulse
  output logic o_pin // Received pin value
);
  assign o_link = i_up;
  assign o_crc = i_err & i_up;
  // Without a link the received value is the inverse of what is sent
  assign o_pin = i_up[0] ? i_val : ~i_val;
endmodule
`default_nettype wire

//--- testbench/lsp_regs_test.sv
`timescale 1ns/100ps
`default_nettype none
module lsp_regs_test;
  import lsp_pkg::*;
  localparam logic [3:0] REV = 4'h6; // Arbitrary revision value
  logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, sel = 1'h0, erst = 1'h0;
  logic tmds = 1'h0, pin_in = 1'h0, val = 1'h0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rd;
  logic [1:0] bact = 2'h0, bst = 2'h0, up = 2'h0, er = 2'h0, link, crc;
  logic pout, poe, p2r, rval, rpin;
  lsp_mode_t rmode;
  logic [2:0] idle_m [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
  int bad_count = 0;
  int checks_done = 0;
  always #12.5 clk = ~clk;
  lsp_regs #(.REVISION(REV)) lsp_regs_i (.i_sys_clk(clk), .i_resetn(rstn),
    .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd), .o_reg_rdata(rd),
    .i_second_port_select(sel), .i_err_reset(erst), .i_crc_err(crc),
    .i_bist_active(bact), .i_bist_start(bst), .i_link_detect(link),
    .i_tmds_clk_valid(tmds), .i_remote_pin_value(rpin),
    .i_general_pin_zero_in(pin_in), .o_general_pin_zero_out(pout),
    .o_general_pin_zero_oe_n(poe), .o_pin_to_remote(p2r),
    .o_remote_side_pin_zero_mode(rmode), .o_remote_side_pin_zero_value(rval));
  lsp_remote_model lsp_remote_model_i (.i_up(up), .i_err(er), .i_val(val),
    .o_link(link), .o_crc(crc), .o_pin(rpin));
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk) addr = a;
    @(negedge clk) chk($sformatf("reg %h", a), e, rd);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk) addr = a;
    wd = d;
    wr = 1'h1;
    @(negedge clk) wr = 1'h0;
  endtask
  task automatic pe(input int n);
    repeat (n) begin
      @(negedge clk) er[0] = 1'h1;
      @(negedge clk) er[0] = 1'h0;
    end
  endtask
  task automatic clr;
    @(negedge clk) erst = 1'h1;
    w(2);
    erst = 1'h0;
    w(1);
  endtask
  task automatic pin(input logic eo, input logic e);
    w(3);
    chk("pin_oe_n", {7'h00, eo}, {7'h00, poe});
    if (!eo) chk("pin_out", {7'h00, e}, {7'h00, pout});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    w(16);
    rstn = 1'h1;
    w(3);
    rc(8'h0A, 8'h00);
    rc(8'h0B, 8'h00);
    rc(8'h0C, 8'h00);
    rc(8'h0D, {REV, 4'h0});
    rc(8'h00, 8'h00);
    $display("reset values done");
    tmds = 1'h1;
    up = 2'h1;
    w(2);
    rc(8'h0C, 8'h05);
    sel = 1'h1;
    rc(8'h0C, 8'h04);
    sel = 1'h0;
    pe(3);
    rc(8'h0A, 8'h03);
    rc(8'h0B, 8'h00);
    rc(8'h0C, 8'h07);
    sel = 1'h1;
    rc(8'h0A, 8'h00);
    sel = 1'h0;
    wreg(8'h0A, 8'hFF);
    wreg(8'h0C, 8'hFF);
    rc(8'h0A, 8'h03);
    rc(8'h0C, 8'h07);
    bact = 2'h1;
    pe(1);
    rc(8'h0C, 8'h0F);
    bst = 2'h1;
    w(1);
    bst = 2'h0;
    rc(8'h0C, 8'h07);
    bact = 2'h0;
    rc(8'h0A, 8'h04);
    clr();
    rc(8'h0A, 8'h00);
    rc(8'h0C, 8'h05);
    pe(256);
    rc(8'h0A, 8'h00);
    rc(8'h0B, 8'h01);
    clr();
    rc(8'h0B, 8'h00);
    $display("counter done");
    bact = 2'h1;
    pe(1);
    bact = 2'h0;
    pe(1);
    up = 2'h0;
    w(2);
    rc(8'h0C, 8'h14);
    up = 2'h1;
    w(2);
    rc(8'h0C, 8'h15);
    clr();
    rc(8'h0C, 8'h05);
    $display("link loss done");
    for (int i = 0; i < 5; i++) begin
      wreg(8'h0D, {5'h01, idle_m[i]});
      pin(1'h1, 1'h0);
    end
    pin_in = 1'h1;
    wreg(8'h0D, 8'h0B);
    w(2);
    chk("to_remote", 8'h01, {7'h00, p2r});
    pin_in = 1'h0;
    w(2);
    chk("to_remote", 8'h00, {7'h00, p2r});
    wreg(8'h0D, 8'h09);
    pin(1'h0, 1'h1);
    wreg(8'h0D, 8'h01);
    pin(1'h0, 1'h0);
    val = 1'h1;
    wreg(8'h0D, 8'h05);
    pin(1'h0, 1'h1);
    up = 2'h0;
    pin(1'h0, 1'h1);
    up = 2'h1;
    val = 1'h0;
    pin(1'h0, 1'h0);
    wreg(8'h0D, 8'h0F);
    pin(1'h0, 1'h0);
    val = 1'h1;
    up = 2'h0;
    pin(1'h0, 1'h1);
    up = 2'h1;
    val = 1'h0;
    $display("pin modes done");
    sel = 1'h1;
    wreg(8'h0D, 8'h0D);
    chk("rmode", 8'h05, {5'h00, rmode});
    chk("rval", 8'h01, {7'h00, rval});
    pin(1'h0, 1'h0);
    rc(8'h0D, {REV, 4'hD});
    sel = 1'h0;
    rc(8'h0D, {REV, 4'hF});
    $display("remote config done");
    final_report();
  end
  initial begin
    #1000000;
    bad_count++;
    final_report();
  end
endmodule
bind lsp_regs lsp_regs_assertions #(.REVISION(REVISION)) lsp_regs_assertions_i (
  .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_second_port_select(i_second_port_select), .i_err_reset(i_err_reset),
  .i_crc_err(i_crc_err), .i_link_detect(i_link_detect),
  .i_tmds_clk_valid(i_tmds_clk_valid),
  .o_general_pin_zero_out(o_general_pin_zero_out),
  .o_general_pin_zero_oe_n(o_general_pin_zero_oe_n),
  .o_remote_side_pin_zero_mode(o_remote_side_pin_zero_mode),
  .o_remote_side_pin_zero_value(o_remote_side_pin_zero_value));
`default_nettype wire
